//--- core/spic_consts.svh
// constants for the serial port clocking and data block
`ifndef SPIC_CONSTS_SVH
`define SPIC_CONSTS_SVH

// ****************************************
// register addresses and reset byte
// ****************************************
`define SPIC_ADDR_CLOCK_DIVIDER 8'h85
`define SPIC_ADDR_DATA_PORT 8'h86
`define SPIC_RESET_BYTE 8'h00

// ****************************************
// framing and slave timing in system clocks
// ****************************************
`define SPIC_BITS_PER_XFER 4'h8
`define SPIC_LAST_BIT 3'h7
`define SPIC_ONE_BIT 3'h1
`define SPIC_ONE_DIV 8'h01
`define SPIC_ONE_HOLD 4'h1
`define SPIC_SLAVE_LAST_HOLD 4'h6

`endif

//--- core/spic_pkg.sv
// types shared by the serial port clocking and data block
package spic_pkg;
    typedef enum logic [2:0] {
        spic_idle = 3'h1,
        spic_run = 3'h2,
        spic_tail = 3'h4
    } spic_state_type;
endpackage

//--- core/spic_shift_if.sv
// shift register carrier between the control and shifter modules
`timescale 1ns/1ps
interface spic_shift_if;
    logic load;
    logic [7:0] load_byte;
    logic sample;
    logic sample_bit;
    logic shift;
    logic [7:0] shift_byte;
    modport ctrl (output load, load_byte, sample, sample_bit, shift,
        input shift_byte);
    modport shifter (input load, load_byte, sample, sample_bit, shift,
        output shift_byte);
endinterface

//--- core/spic_shifter.sv
// single eight bit shift register, msb first
`timescale 1ns/1ps
`include "spic_consts.svh"
module spic_shifter (
    input wire logic sys_clk,
    input wire logic rst_n,
    spic_shift_if.shifter port
);
    logic [7:0] sreg;
    logic [7:0] next_sreg;
    logic in_bit;
    logic [7:0] next_in_bit;

    always_comb begin
        next_sreg = sreg;
        next_in_bit = {7'h00, in_bit};
        if (port.load) begin
            next_sreg = port.load_byte;
        end else if (port.shift) begin
            next_sreg = {sreg[6:0], in_bit};
        end
        if (port.sample) begin
            next_in_bit = {7'h00, port.sample_bit};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sreg <= `SPIC_RESET_BYTE;
            in_bit <= 1'b0;
        end else begin
            sreg <= next_sreg;
            in_bit <= next_in_bit[0];
        end
    end

    assign port.shift_byte = sreg;
endmodule

//--- core/spic_port.sv
// serial port clocking, data register and master/slave shift sequencing
// What this block does
// - master clock is system clock over 2(div+1)
// - data write fills tx buffer, starts master
// - data read returns the receive buffer
// - polarity one inverts the serial clock
// - slave drives miso within four clocks
// - slave releases miso within four clocks
// - slave updates miso within four clocks
// - phase one, miso changes 6-8 clocks late
// - slave samples mid bit; master one clock before end (phase zero, divider not zero), else mid bit
// - done flag sticky; tx empty tracks buffer
`timescale 1ns/1ps
`include "spic_consts.svh"
module spic_port (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic port_enable,
    input wire logic master_mode,
    input wire logic clock_polarity_sel,
    input wire logic clock_phase_sel,
    input wire logic done_flag_clear,
    output logic transfer_done_flag,
    output logic tx_buffer_empty,
    output logic sck_out,
    output logic sck_oe,
    input wire logic sck_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic mosi_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic miso_in,
    input wire logic slave_select_n
);
    spic_shift_if sh ();

    spic_shifter u_shifter (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .port(sh)
    );

    // ****************************************
    // registers and flags
    // ****************************************
    logic [7:0] clock_divide_value;
    logic [7:0] tx_buffer;
    logic [7:0] rx_buffer;
    logic [7:0] next_clock_divide_value;
    logic [7:0] next_tx_buffer;
    logic [7:0] next_rx_buffer;
    logic next_done_flag;
    logic next_tx_empty;
    logic wr_div;
    logic wr_data;
    logic xfer_end;
    logic capture_rx;
    logic load_now;

    assign wr_div = reg_write && reg_addr == `SPIC_ADDR_CLOCK_DIVIDER;
    assign wr_data = reg_write && reg_addr == `SPIC_ADDR_DATA_PORT;

    always_comb begin
        next_clock_divide_value = clock_divide_value;
        next_tx_buffer = tx_buffer;
        next_rx_buffer = rx_buffer;
        next_done_flag = transfer_done_flag;
        next_tx_empty = tx_buffer_empty;
        if (wr_div) begin
            next_clock_divide_value = reg_wdata;
        end
        // a write while the buffer is still full is dropped
        if (wr_data && tx_buffer_empty) begin
            next_tx_buffer = reg_wdata;
            next_tx_empty = 1'b0;
        end
        if (load_now) begin
            next_tx_empty = 1'b1;
        end
        if (done_flag_clear) begin
            next_done_flag = 1'b0;
        end
        // taken one clock after the last shift so bit zero is in place
        if (capture_rx) begin
            next_rx_buffer = sh.shift_byte;
            next_done_flag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            clock_divide_value <= `SPIC_RESET_BYTE;
            tx_buffer <= `SPIC_RESET_BYTE;
            rx_buffer <= `SPIC_RESET_BYTE;
            transfer_done_flag <= 1'b0;
            tx_buffer_empty <= 1'b1;
        end else begin
            clock_divide_value <= next_clock_divide_value;
            tx_buffer <= next_tx_buffer;
            rx_buffer <= next_rx_buffer;
            transfer_done_flag <= next_done_flag;
            tx_buffer_empty <= next_tx_empty;
        end
    end

    always_comb begin
        reg_rdata = `SPIC_RESET_BYTE;
        if (reg_read && reg_addr == `SPIC_ADDR_DATA_PORT) begin
            reg_rdata = rx_buffer;
        end else if (reg_read && reg_addr == `SPIC_ADDR_CLOCK_DIVIDER) begin
            reg_rdata = clock_divide_value;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    spic_pkg::spic_state_type state;
    spic_pkg::spic_state_type next_state;
    logic [7:0] div_cnt;
    logic [7:0] next_div_cnt;
    logic [3:0] edge_cnt;
    logic [3:0] next_edge_cnt;
    logic sck_phase;
    logic next_sck_phase;
    logic sck_prev;
    logic [3:0] tail_cnt;
    logic [3:0] next_tail_cnt;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [7:0] mid_cnt;
    logic [7:0] next_mid_cnt;
    logic ss_prev;
    logic miso_en;
    logic next_miso_en;
    logic miso_q;
    logic next_miso_q;
    logic mosi_q;
    logic next_mosi_q;
    logic half_tick;
    logic sck_norm;
    logic lead_edge;
    logic trail_edge;
    logic sample_edge;
    logic shift_edge;
    logic slave_sel;

    // slave clock brought back to polarity zero
    assign sck_norm = sck_in ^ clock_polarity_sel;
    assign lead_edge = sck_norm && !sck_prev;
    assign trail_edge = !sck_norm && sck_prev;
    assign sample_edge = clock_phase_sel ? trail_edge : lead_edge;
    assign shift_edge = clock_phase_sel ? lead_edge : trail_edge;
    assign slave_sel = port_enable && !master_mode && !slave_select_n;
    assign half_tick = div_cnt == clock_divide_value;
    assign load_now = state == spic_pkg::spic_idle && !tx_buffer_empty &&
        port_enable && (master_mode || slave_sel);

    always_comb begin
        next_state = state;
        next_div_cnt = div_cnt;
        next_edge_cnt = edge_cnt;
        next_sck_phase = sck_phase;
        next_tail_cnt = tail_cnt;
        next_bit_cnt = bit_cnt;
        next_mid_cnt = mid_cnt;
        next_miso_en = slave_sel;
        next_miso_q = miso_q;
        next_mosi_q = mosi_q;
        xfer_end = 1'b0;
        sh.load = load_now;
        sh.load_byte = tx_buffer;
        sh.sample = 1'b0;
        sh.sample_bit = master_mode ? miso_in : mosi_in;
        sh.shift = 1'b0;
        unique case (state)
            spic_pkg::spic_idle: begin
                next_div_cnt = `SPIC_RESET_BYTE;
                next_edge_cnt = 4'h0;
                next_bit_cnt = 3'h0;
                next_mid_cnt = `SPIC_RESET_BYTE;
                next_sck_phase = 1'b0;
                if (load_now) begin
                    next_state = spic_pkg::spic_run;
                    next_mosi_q = tx_buffer[7];
                    next_miso_q = tx_buffer[7];
                end
            end
            spic_pkg::spic_run: begin
                if (master_mode) begin
                    next_div_cnt = half_tick ? `SPIC_RESET_BYTE :
                        div_cnt + `SPIC_ONE_DIV;
                    // miso taken one system clock before the bit closes
                    if (sck_phase && !clock_phase_sel &&
                            div_cnt + `SPIC_ONE_DIV == clock_divide_value)
                            begin
                        sh.sample = 1'b1;
                    end
                    // divider zero: a bit is two clocks, sample at its middle
                    if (!sck_phase && !clock_phase_sel && half_tick &&
                            clock_divide_value == `SPIC_RESET_BYTE) begin
                        sh.sample = 1'b1;
                    end
                    if (!sck_phase && clock_phase_sel &&
                            div_cnt == clock_divide_value) begin
                        sh.sample = 1'b1;
                    end
                    if (half_tick) begin
                        next_sck_phase = !sck_phase;
                        next_edge_cnt = edge_cnt + `SPIC_ONE_HOLD;
                        if (sck_phase) begin
                            sh.shift = 1'b1;
                            next_bit_cnt = bit_cnt + `SPIC_ONE_BIT;
                            next_mosi_q = sh.shift_byte[6];
                            if (bit_cnt == `SPIC_LAST_BIT) begin
                                xfer_end = 1'b1;
                                next_state = spic_pkg::spic_idle;
                            end
                        end
                    end
                end else begin
                    // slave: sample latched at the mid bit sampling edge
                    if (sample_edge) begin
                        sh.sample = 1'b1;
                        next_mid_cnt = mid_cnt + `SPIC_ONE_DIV;
                    end
                    if (shift_edge && mid_cnt != `SPIC_RESET_BYTE) begin
                        sh.shift = 1'b1;
                        next_mid_cnt = mid_cnt - `SPIC_ONE_DIV;
                        next_bit_cnt = bit_cnt + `SPIC_ONE_BIT;
                        next_miso_q = sh.shift_byte[6];
                    end
                    if (sample_edge && bit_cnt == `SPIC_LAST_BIT) begin
                        next_state = spic_pkg::spic_tail;
                        next_tail_cnt = 4'h0;
                    end
                    if (!slave_sel) begin
                        next_state = spic_pkg::spic_idle;
                    end
                end
            end
            spic_pkg::spic_tail: begin
                // final bit shifts in, miso moves six clocks after edge
                next_tail_cnt = tail_cnt + `SPIC_ONE_HOLD;
                if (tail_cnt == 4'h0) begin
                    sh.shift = 1'b1;
                    xfer_end = 1'b1;
                end
                if (tail_cnt == `SPIC_SLAVE_LAST_HOLD - `SPIC_ONE_HOLD)
                        begin
                    next_miso_q = tx_buffer[7];
                    next_state = spic_pkg::spic_idle;
                end
            end
            default: begin
                next_state = spic_pkg::spic_idle;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= spic_pkg::spic_idle;
            capture_rx <= 1'b0;
            div_cnt <= `SPIC_RESET_BYTE;
            edge_cnt <= 4'h0;
            sck_phase <= 1'b0;
            sck_prev <= 1'b0;
            tail_cnt <= 4'h0;
            bit_cnt <= 3'h0;
            mid_cnt <= `SPIC_RESET_BYTE;
            ss_prev <= 1'b1;
            miso_en <= 1'b0;
            miso_q <= 1'b0;
            mosi_q <= 1'b0;
        end else begin
            state <= next_state;
            capture_rx <= xfer_end;
            div_cnt <= next_div_cnt;
            edge_cnt <= next_edge_cnt;
            sck_phase <= next_sck_phase;
            sck_prev <= sck_norm;
            tail_cnt <= next_tail_cnt;
            bit_cnt <= next_bit_cnt;
            mid_cnt <= next_mid_cnt;
            ss_prev <= slave_select_n;
            miso_en <= next_miso_en;
            miso_q <= next_miso_q;
            mosi_q <= next_mosi_q;
        end
    end

    // ****************************************
    // pins
    // ****************************************
    assign sck_out = sck_phase ^ clock_polarity_sel;
    assign sck_oe = port_enable && master_mode;
    assign mosi_out = mosi_q;
    assign mosi_oe = port_enable && master_mode;
    assign miso_out = miso_q;
    assign miso_oe = miso_en;
endmodule

//--- verification/spic_port_props.sv
// checker for the serial port clocking and data block
`timescale 1ns/1ps
module spic_port_props (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic port_enable,
    input wire logic master_mode,
    input wire logic done_flag_clear,
    input wire logic transfer_done_flag,
    input wire logic tx_buffer_empty,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic miso_oe,
    input wire logic slave_select_n
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    logic [7:0] div;
    logic [8:0] gap;
    logic sck_q;
    // gap saturates so a long idle never wraps into a short half period
    always_ff @(posedge sys_clk) begin
        sck_q <= sck_out;
        if (!rst_n) begin
            div <= 8'h00;
            gap <= 9'h000;
        end else begin
            if (reg_write && reg_addr == 8'h85)
                div <= reg_wdata;
            if (sck_out != sck_q)
                gap <= 9'h001;
            else if (gap != 9'h1ff)
                gap <= gap + 9'h001;
        end
    end
    // ******
    // checks
    // ******
    chk_miso_drive: assert property (
        $fell(slave_select_n) && !master_mode && port_enable
        |-> ##[1:4] miso_oe) else $error("miso not driven");
    chk_miso_release: assert property (
        $rose(slave_select_n) |-> ##[1:4] !miso_oe)
        else $error("miso not released");
    chk_sck_half: assert property (
        sck_out != sck_q && sck_oe && master_mode
        |-> gap >= {1'b0, div} + 9'h001) else $error("sck too fast");
    chk_empty_fall: assert property (
        reg_write && reg_addr == 8'h86 && tx_buffer_empty && master_mode
        && port_enable |=> !tx_buffer_empty) else $error("empty kept");
    chk_done_sticky: assert property (
        transfer_done_flag && !done_flag_clear |=> transfer_done_flag)
        else $error("done flag lost");
    chk_div_read: assert property (
        reg_read && reg_addr == 8'h85 |-> reg_rdata == div)
        else $error("divider readback");
    chk_unmapped_zero: assert property (
        reg_read && reg_addr != 8'h85 && reg_addr != 8'h86
        |-> reg_rdata == 8'h00) else $error("unmapped read");
    chk_idle_zero: assert property (
        !reg_read |-> reg_rdata == 8'h00) else $error("idle read data");
    cov_master_done: cover property ($rose(transfer_done_flag) && master_mode);
    cov_slave_end: cover property ($fell(miso_oe));
    cov_data_read: cover property (reg_read && reg_addr == 8'h86);
endmodule
bind spic_port spic_port_props u_spic_port_props (.sys_clk, .rst_n,
    .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata,
    .port_enable, .master_mode, .done_flag_clear, .transfer_done_flag,
    .tx_buffer_empty, .sck_out, .sck_oe, .miso_oe, .slave_select_n);

//--- verification/spic_slave_model.sv
// external serial slave facing the port in master mode, phase zero
`timescale 1ns/1ps
module spic_slave_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic pol,
    input wire logic sel_n,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte
);
    logic [7:0] shreg;
    logic last = 1'b0;
    // released line floats: show the inverse of the last bit, not a hold
    assign miso = sel_n ? ~last : shreg[7];
    always @(negedge sel_n) shreg = tx_byte;
    always @(sck) begin
        if (!sel_n && (sck ^ pol))
            rx_byte = {rx_byte[6:0], mosi};
        else if (!sel_n) begin
            last = shreg[7];
            shreg = {shreg[6:0], 1'b0};
        end
    end
endmodule

//--- verification/tb_top.sv
// self-checking bench for the serial port clocking and data block
`timescale 1ns/1ps
module tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic port_enable = 1'b1, master_mode = 1'b1, done_flag_clear = 1'b0;
    logic clock_polarity_sel = 1'b0, clock_phase_sel = 1'b0;
    logic sck_in = 1'b0, mosi_in = 1'b0, slave_select_n = 1'b1;
    logic part_sel_n = 1'b1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, part_tx = 8'h00;
    logic [7:0] reg_rdata, part_rx;
    logic transfer_done_flag, tx_buffer_empty, sck_out, sck_oe;
    logic mosi_out, mosi_oe, miso_out, miso_oe, miso_in;
    int fails = 0, checks = 0;
    spic_port u_spic_port (.sys_clk, .rst_n, .reg_addr, .reg_write,
        .reg_read, .reg_wdata, .reg_rdata, .port_enable, .master_mode,
        .clock_polarity_sel, .clock_phase_sel, .done_flag_clear,
        .transfer_done_flag, .tx_buffer_empty, .sck_out, .sck_oe, .sck_in,
        .mosi_out, .mosi_oe, .mosi_in, .miso_out, .miso_oe, .miso_in,
        .slave_select_n);
    spic_slave_model u_spic_slave_model (.sck(sck_out), .mosi(mosi_out),
        .pol(clock_polarity_sel), .sel_n(part_sel_n), .tx_byte(part_tx),
        .miso(miso_in), .rx_byte(part_rx));
    initial forever #4 sys_clk = ~sys_clk;
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        cmp8({7'h00, got}, {7'h00, exp});
    endtask
    // sample one ns past the edge so the design's updates have landed
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        #1 cmp8(reg_rdata, exp);
        @(posedge sys_clk);
        reg_read <= 1'b0;
    endtask
    task automatic sck_wait(output int n);
        logic e;
        e = sck_out;
        for (n = 0; n < 600 && sck_out === e; n++)
            step();
    endtask
    // ******
    // scenarios
    // ******
    task automatic t_reset;
        cmp1(tx_buffer_empty, 1'b1);
        cmp1(transfer_done_flag, 1'b0);
        cmp1(sck_out, 1'b0);
        rd_chk(8'h85, 8'h00);
        rd_chk(8'h86, 8'h00);
        rd_chk(8'h87, 8'h00);
        wr_reg(8'h85, 8'h01);
        rd_chk(8'h85, 8'h01);
    endtask
    task automatic t_master(input logic p, input logic [7:0] d, s);
        int n;
        @(posedge sys_clk);
        clock_polarity_sel <= p;
        part_tx <= s;
        repeat (4) step();
        cmp1(sck_out, p);
        cmp1(sck_oe, 1'b1);
        cmp1(mosi_oe, 1'b1);
        @(posedge sys_clk);
        part_sel_n <= 1'b0;
        wr_reg(8'h86, d);
        sck_wait(n);
        sck_wait(n);
        cmp8(n[7:0], 8'h02);
        for (n = 0; n < 300 && transfer_done_flag !== 1'b1; n++)
            step();
        cmp1(transfer_done_flag, 1'b1);
        cmp1(sck_out, p);
        cmp8(part_rx, d);
        rd_chk(8'h86, s);
        part_sel_n <= 1'b1;
        done_flag_clear <= 1'b1;
        @(posedge sys_clk);
        done_flag_clear <= 1'b0;
        step();
        cmp1(transfer_done_flag, 1'b0);
    endtask
    // the bench plays the external master: select, then 8 slow bits
    task automatic t_slave(input logic ph, input logic [7:0] d, m);
        logic [7:0] got;
        @(posedge sys_clk);
        master_mode <= 1'b0;
        clock_phase_sel <= ph;
        clock_polarity_sel <= 1'b0;
        slave_select_n <= 1'b0;
        wr_reg(8'h86, d);
        repeat (3) step();
        cmp1(miso_oe, 1'b1);
        cmp1(sck_oe, 1'b0);
        cmp1(mosi_oe, 1'b0);
        // phase one shifts on the rising edge and samples on the falling
        for (int i = 7; i >= 0; i--) begin
            @(posedge sys_clk);
            mosi_in <= m[i];
            if (ph)
                sck_in <= 1'b1;
            repeat (6) @(posedge sys_clk);
            got[i] = miso_out;
            sck_in <= !ph;
            repeat (6) @(posedge sys_clk);
            sck_in <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
        if (ph)
            cmp1(miso_out, d[7]);
        slave_select_n <= 1'b1;
        mosi_in <= ~mosi_in;
        repeat (5) step();
        cmp1(miso_oe, 1'b0);
        cmp8(got, d);
        cmp1(transfer_done_flag, 1'b1);
        rd_chk(8'h86, m);
        done_flag_clear <= 1'b1;
        @(posedge sys_clk);
        done_flag_clear <= 1'b0;
    endtask
    task automatic final_report;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_master(1'b0, 8'ha5, 8'h3c);
        t_master(1'b1, 8'h5a, 8'hc3);
        t_slave(1'b0, 8'h96, 8'h69);
        t_slave(1'b1, 8'h96, 8'ha5);
        final_report();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        final_report();
    end
endmodule
